// ### core/cfa_cfg.svh
// Constants of the condition-flag and address-formation unit.
// Assumes a 32-bit APB register window with word-aligned offsets.
`ifndef CFA_CFG_SVH
`define CFA_CFG_SVH

// Register byte offsets
`define CFA_OFS_FLAGS    12'h000
`define CFA_OFS_OPND     12'h004
`define CFA_OFS_EXEC     12'h008
`define CFA_OFS_RESULT   12'h00C
`define CFA_OFS_ADDRCTL  12'h010
`define CFA_OFS_PC       12'h014
`define CFA_OFS_EADDR    12'h018
`define CFA_OFS_STATUS   12'h01C

// Flag byte: bits that always read one, and reset value
`define CFA_FLAG_ONES    8'h60
`define CFA_FLAG_RESET   8'h68
`define CFA_PC_RESET     16'h0000

// Operand and literal fields
`define CFA_DIR_PAGE     8'h00
`define CFA_BCD_LOW      8'h06
`define CFA_BCD_HIGH     8'h60
`define CFA_BCD_MAXBYTE  8'h99
`define CFA_BCD_MAXNIB   4'h9

`endif

// ### core/cfa_pkg.sv
// Types of the condition-flag and address-formation unit.
// Assumes cfa_cfg.svh is not needed here; values live in the header.
package cfa_pkg;

  // Flag byte, bit 7 down to bit 0
  typedef struct packed {
    logic signedWrap;    // bit 7
    logic one6;          // bit 6
    logic one5;          // bit 5
    logic nibbleCarry;   // bit 4
    logic blockMaskable; // bit 3
    logic msbResult;     // bit 2
    logic allBitsLow;    // bit 1
    logic borrowOut;     // bit 0
  } cfa_flags_t;

  // Operations run by a write to the execute register
  typedef enum logic [4:0] {
    OP_SUM, OP_SUMC, OP_DIFF, OP_DIFFC, OP_AND, OP_OR, OP_XOR,
    OP_LOAD8, OP_LOAD16, OP_BCD, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR,
    OP_UNMASK, OP_MASK, OP_ACC_TO_FLAGS, OP_FLAGS_TO_ACC,
    OP_GREATER, OP_GREATER_EQ, OP_LESS_EQ, OP_LESS,
    OP_BIT_LOW, OP_BIT_HIGH, OP_CMP_EQ, OP_DEC_NZ
  } cfa_op_t;

  // Operand addressing modes
  typedef enum logic [2:0] {
    MODE_REGISTER, MODE_PC_OFFSET, MODE_LITERAL, MODE_PAGE_ZERO, MODE_FULL
  } cfa_mode_t;

  // Formed operand address
  typedef struct packed {
    logic        memAccess;
    logic [15:0] addr;
  } cfa_ea_t;

endpackage

// ### core/cfa_core.sv
// Condition flags, flag update logic and operand-address formation.
// Assumes an APB master on clk and a sequencer that pulses instrBoundary
// and stackSaved; all inputs are synchronous to clk.
//
// How it works
// - Flag byte bits 6 and 5 always read as one.
// - Bit 7 flags signed overflow; the four signed branches test it.
// - Bit 4 catches carry from bit 3 into bit 4 on sums.
// - BCD adjust adds a correction chosen by bits 4 and 0.
// - Bit 3 set blocks maskable interrupts; clear accepts them.
// - Bit 3 is set after registers are stacked, before the handler runs.
// - No interrupt at the boundary right after unmask or accumulator-to-flags.
// - Bit 2 follows result top bit, also for 8 and 16 bit moves.
// - Bit 1 set when result is all zero, moves included.
// - Bit 0 is carry or borrow; bit tests, shifts, rotates update it.
// - One flat 16-bit address space for every operand access.
// - Test-and-branch ops test an operand, then branch by pc offset.
// - Register mode makes no memory access for operands.
// - Pc offset: signed byte, sign-extended, added to the program counter.
// - Literal mode: operand follows opcode, high byte first.
// - Page zero mode: upper address byte is 0x00.
// - Full mode: 16-bit address from next two bytes, high first.
`include "cfa_cfg.svh"

module cfa_core (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Interrupt sequencing
  input  wire logic                instrBoundary,
  input  wire logic                maskIrq,
  input  wire logic                stackSaved,
  output logic                     intAccept,
  // Flag and operand address view
  output cfa_pkg::cfa_flags_t      flags,
  output cfa_pkg::cfa_ea_t         opAddr
);
  import cfa_pkg::*;

  logic [7:0]  opA;
  logic [7:0]  opB;
  logic [15:0] result;
  logic        taken;
  cfa_mode_t   mode;
  logic [7:0]  progByte0;
  logic [7:0]  progByte1;
  logic [15:0] pc;
  logic [15:0] literal;
  logic        suppress;
  logic        inService;

  logic        setupPh;
  logic        accessWr;
  logic        mapped;
  logic        execWr;
  cfa_op_t     execOp;
  logic [2:0]  bitSel;

  cfa_flags_t  next_flags;
  logic [15:0] next_result;
  logic        next_taken;
  cfa_ea_t     next_ea;
  logic        irqTake;

  // APB decode; single-wait-free slave answers in the access phase
  assign setupPh  = psel & ~penable;
  assign accessWr = psel & penable & pwrite & mapped;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign execWr   = accessWr && paddr == `CFA_OFS_EXEC;
  assign execOp   = cfa_op_t'(pwdata[4:0]);
  assign bitSel   = pwdata[7:5];

  always_comb begin
    unique case (paddr)
      `CFA_OFS_FLAGS, `CFA_OFS_OPND, `CFA_OFS_EXEC, `CFA_OFS_RESULT,
      `CFA_OFS_ADDRCTL, `CFA_OFS_PC, `CFA_OFS_EADDR, `CFA_OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Flag and result computation for one executed operation
  always_comb begin
    logic [8:0] wide;
    logic [4:0] low;
    logic       cin;
    logic [7:0] corr;
    logic       bcdCarry;
    logic [7:0] r8;
    wide        = 9'h000;
    low         = 5'h00;
    corr        = 8'h00;
    bcdCarry    = 1'b0;
    r8          = 8'h00;
    cin         = flags.borrowOut;
    next_flags  = flags;
    next_result = result;
    next_taken  = 1'b0;
    unique case (execOp)
      OP_SUM, OP_SUMC: begin
        wide = {1'b0, opA} + {1'b0, opB} + {8'h00, (execOp == OP_SUMC) & cin};
        low  = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, (execOp == OP_SUMC) & cin};
        r8   = wide[7:0];
        next_flags.nibbleCarry = low[4];
        next_flags.borrowOut   = wide[8];
        next_flags.signedWrap  = (opA[7] == opB[7]) && (r8[7] != opA[7]);
      end
      OP_DIFF, OP_DIFFC: begin
        wide = {1'b0, opA} - {1'b0, opB} - {8'h00, (execOp == OP_DIFFC) & cin};
        r8   = wide[7:0];
        next_flags.borrowOut  = wide[8];
        next_flags.signedWrap = (opA[7] != opB[7]) && (r8[7] != opA[7]);
      end
      OP_AND, OP_OR, OP_XOR: begin
        r8 = (execOp == OP_AND) ? (opA & opB) : (execOp == OP_OR) ? (opA | opB) : (opA ^ opB);
        next_flags.signedWrap = 1'b0;
      end
      OP_LOAD8: begin
        r8 = opB;
        next_flags.signedWrap = 1'b0;
      end
      OP_BCD: begin
        // Correction from the nibble carry and carry of the prior sum
        if (flags.borrowOut || opA > `CFA_BCD_MAXBYTE) begin
          corr     = corr | `CFA_BCD_HIGH;
          bcdCarry = 1'b1;
        end
        if (flags.nibbleCarry || opA[3:0] > `CFA_BCD_MAXNIB) begin
          corr = corr | `CFA_BCD_LOW;
        end
        r8 = opA + corr;
        next_flags.borrowOut = bcdCarry;
      end
      OP_SHL, OP_ROTL: begin
        r8 = {opA[6:0], (execOp == OP_ROTL) & cin};
        next_flags.borrowOut  = opA[7];
        next_flags.signedWrap = r8[7] ^ opA[7];
      end
      OP_SHR, OP_ROTR: begin
        r8 = {(execOp == OP_ROTR) & cin, opA[7:1]};
        next_flags.borrowOut  = opA[0];
        next_flags.signedWrap = r8[7] ^ opA[0];
      end
      OP_FLAGS_TO_ACC: r8 = flags;
      default: r8 = opA;
    endcase
    // Result-derived flags for data-producing operations
    unique case (execOp)
      OP_SUM, OP_SUMC, OP_DIFF, OP_DIFFC, OP_AND, OP_OR, OP_XOR,
      OP_LOAD8, OP_BCD, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR: begin
        next_result          = {8'h00, r8};
        next_flags.msbResult = r8[7];
        next_flags.allBitsLow = (r8 == 8'h00);
      end
      OP_LOAD16: begin
        next_result           = {opA, opB};
        next_flags.msbResult  = opA[7];
        next_flags.allBitsLow = ({opA, opB} == 16'h0000);
        next_flags.signedWrap = 1'b0;
      end
      OP_FLAGS_TO_ACC: next_result = {8'h00, r8};
      OP_UNMASK: next_flags.blockMaskable = 1'b0;
      OP_MASK: next_flags.blockMaskable = 1'b1;
      OP_ACC_TO_FLAGS: next_flags = opA | `CFA_FLAG_ONES;
      // Branches: test first, target later by pc offset
      OP_GREATER: next_taken = ~(flags.allBitsLow | (flags.msbResult ^ flags.signedWrap));
      OP_GREATER_EQ: next_taken = ~(flags.msbResult ^ flags.signedWrap);
      OP_LESS_EQ: next_taken = flags.allBitsLow | (flags.msbResult ^ flags.signedWrap);
      OP_LESS: next_taken = flags.msbResult ^ flags.signedWrap;
      OP_BIT_LOW, OP_BIT_HIGH: begin
        next_flags.borrowOut = opB[bitSel];
        next_taken = (execOp == OP_BIT_HIGH) ? opB[bitSel] : ~opB[bitSel];
      end
      OP_CMP_EQ: next_taken = (opA == opB);
      OP_DEC_NZ: begin
        next_result = {8'h00, opA - 8'h01};
        next_taken  = (opA != 8'h01);
      end
      default: next_taken = 1'b0;
    endcase
  end

  // Address formation from mode, program bytes and pc
  always_comb begin
    next_ea = '0;
    unique case (mode)
      MODE_REGISTER: next_ea = '0;
      MODE_PC_OFFSET: next_ea = '{1'b0, pc + {{8{progByte0[7]}}, progByte0}};
      MODE_LITERAL: next_ea = '{1'b1, pc};
      MODE_PAGE_ZERO: next_ea = '{1'b1, {`CFA_DIR_PAGE, progByte0}};
      MODE_FULL: next_ea = '{1'b1, {progByte0, progByte1}};
      default: next_ea = '0;
    endcase
  end

  assign literal = {progByte0, progByte1};
  assign irqTake = instrBoundary & maskIrq & ~flags.blockMaskable & ~suppress;

  // Flag register: software writes, executed ops, interrupt mask set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= `CFA_FLAG_RESET;
    end else if (stackSaved && inService) begin
      flags.blockMaskable <= 1'b1;
    end else if (accessWr && paddr == `CFA_OFS_FLAGS) begin
      flags <= pwdata[7:0] | `CFA_FLAG_ONES;
    end else if (execWr) begin
      flags <= next_flags | `CFA_FLAG_ONES;
    end
  end

  // Operands, result and branch outcome
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opA    <= 8'h00;
      opB    <= 8'h00;
      result <= 16'h0000;
      taken  <= 1'b0;
    end else if (accessWr && paddr == `CFA_OFS_OPND) begin
      opA <= pwdata[7:0];
      opB <= pwdata[15:8];
    end else if (execWr) begin
      result <= next_result;
      taken  <= next_taken;
    end
  end

  // Program counter and addressing controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc        <= `CFA_PC_RESET;
      mode      <= MODE_REGISTER;
      progByte0 <= 8'h00;
      progByte1 <= 8'h00;
    end else if (accessWr && paddr == `CFA_OFS_PC) begin
      pc <= pwdata[15:0];
    end else if (accessWr && paddr == `CFA_OFS_ADDRCTL) begin
      mode      <= cfa_mode_t'(pwdata[2:0]);
      progByte0 <= pwdata[15:8];
      progByte1 <= pwdata[23:16];
    end else if (execWr && next_taken) begin
      pc <= pc + {{8{progByte0[7]}}, progByte0};
    end
  end

  // Registered operand address in the flat 16-bit space
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opAddr <= '0;
    end else begin
      opAddr <= next_ea;
    end
  end

  // Interrupt acceptance and one-boundary hold-off after unmasking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      suppress  <= 1'b0;
      inService <= 1'b0;
      intAccept <= 1'b0;
    end else begin
      intAccept <= irqTake;
      if (execWr && (execOp == OP_UNMASK || execOp == OP_ACC_TO_FLAGS)) begin
        suppress <= 1'b1;
      end else if (instrBoundary) begin
        suppress <= 1'b0;
      end
      if (irqTake) begin
        inService <= 1'b1;
      end else if (stackSaved) begin
        inService <= 1'b0;
      end
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh) begin
      unique case (paddr)
        `CFA_OFS_FLAGS:   prdata <= {24'h00_0000, flags};
        `CFA_OFS_OPND:    prdata <= {16'h0000, opB, opA};
        `CFA_OFS_RESULT:  prdata <= {15'h0000, taken, result};
        `CFA_OFS_ADDRCTL: prdata <= {8'h00, literal[7:0], literal[15:8], 5'h00, mode};
        `CFA_OFS_PC:      prdata <= {16'h0000, pc};
        `CFA_OFS_EADDR:   prdata <= {15'h0000, opAddr};
        `CFA_OFS_STATUS:  prdata <= {29'h0000_0000, inService, suppress, maskIrq};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### verif/cfa_core_asserts.sv
// Checker of flag, interrupt and address behaviour of cfa_core.
// Assumes it is bound to cfa_core and sees only its ports.
`include "cfa_cfg.svh"
module cfa_core_asserts (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pslverr,
  // Interrupt and views
  input wire logic                instrBoundary,
  input wire logic                maskIrq,
  input wire logic                stackSaved,
  input wire logic                intAccept,
  input wire cfa_pkg::cfa_flags_t flags,
  input wire cfa_pkg::cfa_ea_t    opAddr
);
  import cfa_pkg::*;
  logic        supp;
  logic [1:0]  ctlAge;
  logic [23:0] ctl;
  logic        wrAcc;
  logic        armOp;
  // Write taking effect, and codes that arm suppression
  assign wrAcc = psel && penable && pwrite;
  assign armOp = pwdata[4:0] == OP_UNMASK || pwdata[4:0] == OP_ACC_TO_FLAGS;
  // Suppression shadow, spent at the next boundary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supp <= 1'b0;
    end else if (wrAcc && paddr == `CFA_OFS_EXEC && armOp) begin
      supp <= 1'b1;
    end else if (instrBoundary) begin
      supp <= 1'b0;
    end
  end
  // Address control shadow and its age in cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl    <= 24'h000000;
      ctlAge <= 2'h0;
    end else if (wrAcc && paddr == `CFA_OFS_ADDRCTL) begin
      ctl    <= pwdata[23:0];
      ctlAge <= 2'h0;
    end else if (ctlAge != 2'h3) begin
      ctlAge <= ctlAge + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ones; flags.one6 && flags.one5; endproperty
  a_ones: assert property (p_ones) else $error("Fixed flag bits not one");
  property p_take; instrBoundary && maskIrq && !flags.blockMaskable && !supp |=> intAccept; endproperty
  a_take: assert property (p_take) else $error("Open interrupt not accepted");
  property p_cause; intAccept |-> $past(instrBoundary && maskIrq && !flags.blockMaskable && !supp); endproperty
  a_cause: assert property (p_cause) else $error("Accept without cause");
  property p_blocked; instrBoundary && flags.blockMaskable |=> !intAccept; endproperty
  a_blocked: assert property (p_blocked) else $error("Accept while masked");
  property p_stack; intAccept ##[1:20] stackSaved |=> flags.blockMaskable; endproperty
  a_stack: assert property (p_stack) else $error("Mask not set after stacking");
  property p_supp; instrBoundary && supp |=> !intAccept; endproperty
  a_supp: assert property (p_supp) else $error("Accept right after unmask");
  property p_page; ctlAge == 2'h3 && ctl[2:0] == MODE_PAGE_ZERO |-> opAddr.addr == {`CFA_DIR_PAGE, ctl[15:8]}; endproperty
  a_page: assert property (p_page) else $error("Page zero address wrong");
  property p_full; ctlAge == 2'h3 && ctl[2:0] == MODE_FULL |-> opAddr.addr == {ctl[15:8], ctl[23:16]}; endproperty
  a_full: assert property (p_full) else $error("Full address wrong");
  property p_reg; ctlAge == 2'h3 && ctl[2:0] == MODE_REGISTER |-> !opAddr.memAccess; endproperty
  a_reg: assert property (p_reg) else $error("Register mode accesses memory");
  c_accept: cover property (intAccept);
  c_stack: cover property (stackSaved);
  c_err: cover property (pslverr);
endmodule

bind cfa_core cfa_core_asserts u_cfa_core_asserts (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pslverr, .instrBoundary, .maskIrq, .stackSaved, .intAccept, .flags, .opAddr);

// ### verif/cfa_core_bench.sv
// Self-checking bench of cfa_core over APB and interrupt pins.
// Assumes cfa_core_asserts is compiled alongside and bound.
`include "cfa_cfg.svh"
module cfa_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import cfa_pkg::*;
  typedef struct {cfa_op_t op; logic [7:0] a, b, fm, fe; logic [15:0] rm, re;} cfa_vec_t;
  logic        clk, rst_n, psel, penable, pwrite, instrBoundary, maskIrq, stackSaved;
  logic        pready, pslverr, intAccept, rdErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  cfa_flags_t  flags;
  cfa_ea_t     opAddr;
  int          fail_count = 0;
  int          cmp_count = 0;
  // Clock at 40 MHz
  always #12.5 clk = ~clk;
  // Design under test
  cfa_core u_cfa_core (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instrBoundary, .maskIrq, .stackSaved, .intAccept, .flags, .opAddr);
  // Verdict and end of run
  task automatic results();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Compare of one value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got 0x%08h expected 0x%08h", $time, got, exp);
    end
  endtask
  // One APB transfer; answer taken at the edge that sees pready
  task automatic apbXfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    @(posedge clk);
  endtask
  // Boundary pulse, then accept looked at in the following cycle
  task automatic bound(input logic exp);
    instrBoundary <= 1'b1;
    @(posedge clk);
    instrBoundary <= 1'b0;
    #1 check({31'h0, intAccept}, {31'h0, exp});
    @(posedge clk);
  endtask
  // Reset value, fixed bits on write, unmapped access
  task automatic tReset();
    check({24'h0, 8'(flags)}, {24'h0, `CFA_FLAG_RESET});
    apbXfer(1'b1, `CFA_OFS_FLAGS, 32'h00000000);
    apbXfer(1'b0, `CFA_OFS_FLAGS, 32'h00000000);
    check(rdData, 32'h00000060);
    apbXfer(1'b1, `CFA_OFS_FLAGS, 32'h0000009F);
    apbXfer(1'b0, `CFA_OFS_FLAGS, 32'h00000000);
    check(rdData, 32'h000000FF);
    apbXfer(1'b0, 12'h020, 32'h00000000);
    check({31'h0, rdErr}, 32'h00000001);
    check(rdData, 32'h00000000);
  endtask
  // Arithmetic, logic, move, adjust and shift flag results in sequence
  task automatic tOps();
    cfa_vec_t v [20] = '{
      '{OP_SUM, 8'h7F, 8'h01, 8'hFF, 8'hF4, 16'h00FF, 16'h0080}, '{OP_SUM, 8'h80, 8'h80, 8'hFF, 8'hE3, 16'h00FF, 16'h0000},
      '{OP_SUMC, 8'h08, 8'h07, 8'hFF, 8'h70, 16'h00FF, 16'h0010}, '{OP_DIFF, 8'h00, 8'h01, 8'hFF, 8'h75, 16'h00FF, 16'h00FF},
      '{OP_LOAD8, 8'h55, 8'h00, 8'h06, 8'h02, 16'h00FF, 16'h0000}, '{OP_LOAD16, 8'h80, 8'h00, 8'h06, 8'h04, 16'hFFFF, 16'h8000},
      '{OP_SUM, 8'h19, 8'h28, 8'hFF, 8'h70, 16'h00FF, 16'h0041}, '{OP_BCD, 8'h41, 8'h00, 8'hFF, 8'h70, 16'h00FF, 16'h0047},
      '{OP_SHL, 8'h81, 8'h00, 8'h87, 8'h81, 16'h00FF, 16'h0002}, '{OP_AND, 8'hF0, 8'h0F, 8'h86, 8'h02, 16'h00FF, 16'h0000},
      '{OP_DIFFC, 8'h10, 8'h05, 8'hFF, 8'h70, 16'h00FF, 16'h000A}, '{OP_ROTR, 8'h01, 8'h00, 8'hFF, 8'hF3, 16'h00FF, 16'h0000},
      '{OP_ROTL, 8'h40, 8'h00, 8'hFF, 8'hF4, 16'h00FF, 16'h0081}, '{OP_XOR, 8'hFF, 8'h0F, 8'hFF, 8'h74, 16'h00FF, 16'h00F0},
      '{OP_FLAGS_TO_ACC, 8'h00, 8'h00, 8'hFF, 8'h74, 16'h00FF, 16'h0074},
      '{OP_ACC_TO_FLAGS, 8'h0B, 8'h00, 8'hFF, 8'h6B, 16'h00FF, 16'h0074},
      '{OP_SHR, 8'h02, 8'h00, 8'hFF, 8'h68, 16'h00FF, 16'h0001}, '{OP_OR, 8'h80, 8'h01, 8'hFF, 8'h6C, 16'h00FF, 16'h0081},
      '{OP_UNMASK, 8'h00, 8'h00, 8'hFF, 8'h64, 16'h00FF, 16'h0081}, '{OP_MASK, 8'h00, 8'h00, 8'hFF, 8'h6C, 16'h00FF, 16'h0081}};
    apbXfer(1'b1, `CFA_OFS_FLAGS, 32'h00000060);
    for (int i = 0; i < 20; i++) begin
      apbXfer(1'b1, `CFA_OFS_OPND, {16'h0, v[i].b, v[i].a});
      apbXfer(1'b1, `CFA_OFS_EXEC, {27'h0, v[i].op});
      apbXfer(1'b0, `CFA_OFS_RESULT, 32'h00000000);
      check({16'h0, rdData[15:0] & v[i].rm}, {16'h0, v[i].re});
      check({24'h0, 8'(flags) & v[i].fm}, {24'h0, v[i].fe});
    end
  endtask
  // Every conditional and test branch, with the offset added when taken
  task automatic tBranch();
    cfa_op_t     bop [8] = '{OP_GREATER, OP_GREATER_EQ, OP_LESS_EQ, OP_LESS, OP_BIT_LOW, OP_BIT_HIGH, OP_CMP_EQ, OP_DEC_NZ};
    logic [7:0]  ba [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h5A, 8'h01};
    logic [7:0]  tk = 8'h6C;
    logic [15:0] pc = 16'h1000;
    apbXfer(1'b1, `CFA_OFS_PC, 32'h00001000);
    apbXfer(1'b1, `CFA_OFS_ADDRCTL, {16'h0, 8'hF0, 5'h0, MODE_PC_OFFSET});
    apbXfer(1'b1, `CFA_OFS_FLAGS, 32'h000000E0);
    for (int i = 0; i < 8; i++) begin
      apbXfer(1'b1, `CFA_OFS_OPND, {16'h0, 8'h5A, ba[i]});
      apbXfer(1'b1, `CFA_OFS_EXEC, {24'h0, 3'h3, bop[i]});
      apbXfer(1'b0, `CFA_OFS_RESULT, 32'h00000000);
      check({31'h0, rdData[16]}, {31'h0, tk[i]});
      pc = tk[i] ? pc + 16'hFFF0 : pc;
      apbXfer(1'b0, `CFA_OFS_PC, 32'h00000000);
      check(rdData & 32'h0000FFFF, {16'h0, pc});
      if (i == 4 || i == 5) check({31'h0, flags.borrowOut}, 32'h00000001);
    end
  endtask
  // Each addressing mode, read back and seen at the port
  task automatic tAddr();
    cfa_mode_t   am [6] = '{MODE_REGISTER, MODE_PC_OFFSET, MODE_LITERAL, MODE_PAGE_ZERO, MODE_FULL, MODE_FULL};
    logic [15:0] ab [6] = '{16'h0000, 16'h0080, 16'h0000, 16'h00A5, 16'h3412, 16'hFFFF};
    logic [16:0] ae [6] = '{17'h00000, 17'h03F80, 17'h14000, 17'h000A5, 17'h01234, 17'h0FFFF};
    logic [16:0] mk [6] = '{17'h1FFFF, 17'h1FFFF, 17'h1FFFF, 17'h0FFFF, 17'h0FFFF, 17'h0FFFF};
    apbXfer(1'b1, `CFA_OFS_PC, 32'h00004000);
    for (int i = 0; i < 6; i++) begin
      apbXfer(1'b1, `CFA_OFS_ADDRCTL, {8'h0, ab[i], 5'h0, am[i]});
      apbXfer(1'b0, `CFA_OFS_EADDR, 32'h00000000);
      check({15'h0, rdData[16:0] & mk[i]}, {15'h0, ae[i]});
      check({15'h0, 17'(opAddr) & mk[i]}, {15'h0, ae[i]});
    end
  endtask
  // Masking, mask set after stacking, no accept right after unmask
  task automatic tIrq();
    apbXfer(1'b1, `CFA_OFS_FLAGS, 32'h00000068);
    maskIrq <= 1'b1;
    bound(1'b0);
    apbXfer(1'b1, `CFA_OFS_FLAGS, 32'h00000060);
    bound(1'b1);
    check({31'h0, flags.blockMaskable}, 32'h00000000);
    stackSaved <= 1'b1;
    @(posedge clk);
    stackSaved <= 1'b0;
    #1 check({31'h0, flags.blockMaskable}, 32'h00000001);
    @(posedge clk);
    apbXfer(1'b1, `CFA_OFS_EXEC, {27'h0, OP_UNMASK});
    bound(1'b0);
    bound(1'b1);
    maskIrq <= 1'b0;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, instrBoundary, maskIrq, stackSaved} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    tReset();
    tOps();
    tBranch();
    tAddr();
    tIrq();
    results();
  end
endmodule
